// ===== design/stq_defs.vh
`ifndef STQ_DEFS_VH
`define STQ_DEFS_VH
// register byte offsets
`define STQ_CTRL       12'h000
`define STQ_STATUS     12'h004
`define STQ_HOLD_EDGE  12'h008
`define STQ_HOLD_PULSE 12'h00C
`define STQ_HOLD_EXT   12'h010
`define STQ_EDGE_CFG   12'h014
`define STQ_PULSE_CFG  12'h018
`define STQ_PULSE_W    12'h01C
`define STQ_AUX_LEVEL  12'h020
`define STQ_LEVEL0     12'h040
`define STQ_LOWER0     12'h060
// ctrl fields
`define STQ_F_MODE_LO  0
`define STQ_F_MODE_HI  1
`define STQ_F_RUN_LO   2
`define STQ_F_RUN_HI   3
`define STQ_F_FINE     4
`define STQ_F_REARM    8
`define STQ_F_FORCE_NEXT 9
// modes
`define STQ_MODE_EDGE  2'd0
`define STQ_MODE_PULSE 2'd1
`define STQ_MODE_EXT   2'd2
`define STQ_RUN_AUTO   2'd0
`define STQ_RUN_TRIG   2'd1
`define STQ_RUN_SINGLE 2'd2
// edge sources
`define STQ_SRC_AUX    3'd4
`define STQ_SRC_MAINS  3'd5
// timing
`define STQ_CLK_MHZ    100
`define STQ_HOLD_MIN_NS 100
`define STQ_HOLD_MIN_CYC ((`STQ_HOLD_MIN_NS * `STQ_CLK_MHZ + 999) / 1000)
`define STQ_HOLD_MAX_S 10
`define STQ_HOLD_MAX_CYC (`STQ_HOLD_MAX_S * `STQ_CLK_MHZ * 1000000)
`define STQ_PW_MIN_CYC 1
`define STQ_AUTO_CYC   32'h0098_9680
`endif

// ===== design/stq_sync.v
`timescale 1ns/1ps
`default_nettype none
module stq_sync
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire [5:0] din,
  output reg  [5:0] dout
);
  reg [5:0] meta;
  // first stage feeds only the second stage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 6'h00;
      dout <= 6'h00;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== design/stq_trigger.v
// How it works
// [R1] rearm delay blocks triggers after acceptance
// [R2] one rearm delay per mode, readback follows mode
// [R3] upper threshold per channel, readable
// [R4] separate lower threshold per channel, readable
// [R5] noise reject: normal or fine sensitivity
// [R6] single crossing level per channel, shared
// [R7] upper threshold write overwrites crossing level
// [R8] auxiliary input has its own level
// [R9] auto mode forces trigger after timeout
// [R10] host avoids auto below 50 Hz
// [R11] triggered/single modes: no trigger, no acquisition
// [R12] edge mode fires on selected edge crossing
// [R13] edge source: channels, auxiliary, mains
// [R14] rising or falling per source except mains
// [R15] direction access targets latest selected source
// [R16] narrow pulse qualified below maximum width
// [R17] positive pulse fires on falling edge
// [R18] negative pulse fires on rising edge
// [R19] pulse mode has own channel selector
// [R20] host selects edge mode before edge setup
// [R21] host selects pulse mode before pulse setup
// [R22] only selected mode's qualifier may trigger
// [R23] single mode disarms until explicit rearm
// [R24] comparators synchronised, widths in clock periods
`timescale 1ns/1ps
`default_nettype none
`include "stq_defs.vh"
module stq_trigger
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  cmp_chan,
  input  wire        cmp_aux,
  input  wire        mains_ref,
  input  wire        ext_trig,
  output reg         trig_out,
  output reg         acq_start,
  output reg         forced,
  output reg         armed,
  output reg         fine_sensitivity
);
  reg  [1:0]  mode;
  reg  [1:0]  run;
  reg  [31:0] hold [0:2];
  reg  [2:0]  edge_src;
  reg  [5:0]  edge_fall;
  reg  [1:0]  pulse_src;
  reg         pulse_neg;
  reg  [31:0] pulse_w;
  reg  [15:0] aux_level;
  reg  [15:0] upper_threshold [0:3];
  reg  [15:0] lower_threshold [0:3];
  reg  [31:0] hold_cnt;
  reg  [31:0] auto_cnt;
  reg  [31:0] width_cnt;
  reg  [5:0]  prev;
  reg  [31:0] next_prdata;
  reg         next_err;
  reg         hit;
  reg  [1:0]  primed;
  wire [5:0]  sync_in;
  wire        wr;
  wire        rd;
  wire        sel_lvl;
  wire        sel_low;
  wire [1:0]  idx;
  wire        cur;
  wire        was;
  wire        pin;
  wire        pprev;
  wire        p_act;
  wire        p_end;
  wire        holding;
  wire        accept;
  wire        disarm;
  integer     i;

  function [31:0] clamp_hold;
    input [31:0] v;
    begin
      if (v < `STQ_HOLD_MIN_CYC)
        clamp_hold = `STQ_HOLD_MIN_CYC;
      else if (v > `STQ_HOLD_MAX_CYC)
        clamp_hold = `STQ_HOLD_MAX_CYC;
      else
        clamp_hold = v;
    end
  endfunction

  // one step of a line between two samples; fall_v picks the direction
  function crossed;
    input cur_v;
    input old_v;
    input fall_v;
    begin
      if (fall_v)
        crossed = old_v && !cur_v;
      else
        crossed = cur_v && !old_v;
    end
  endfunction

  // 32-byte block decode for per-channel words
  // bit 4 is not decoded, so the upper half of each block aliases
  function in_block;
    input [11:0] addr;
    input [11:0] base;
    begin
      in_block = (addr[11:5] == base[11:5]);
    end
  endfunction

  // comparator and mains inputs go through two flops [R24]
  stq_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({mains_ref, cmp_aux, cmp_chan}),
    .dout    (sync_in)
  );

  // writes land on the edge that completes the transfer
  assign wr      = psel && penable && pwrite && pready;
  assign rd      = psel && penable && !pwrite && !pready;
  assign sel_lvl = in_block(paddr, `STQ_LEVEL0);
  assign sel_low = in_block(paddr, `STQ_LOWER0);
  assign idx     = paddr[3:2];
  assign holding = (hold_cnt != 32'h0000_0000);
  assign accept  = armed && !holding && hit && (primed == 2'd3);
  // a single-mode trigger in this cycle outranks a rearm write
  assign disarm  = accept && (run == `STQ_RUN_SINGLE);

  // edge source: channels, auxiliary, or mains (mains always rising)
  assign cur = sync_in[edge_src];
  assign was = prev[edge_src];

  // pulse: positive pulse ends falling, negative ends rising
  assign pin   = sync_in[pulse_src] ^ pulse_neg;
  assign pprev = prev[pulse_src] ^ pulse_neg;
  assign p_act = pin;
  assign p_end = crossed(pin, pprev, 1'b1);

  always @*
  begin
    hit = 1'b0;
    case (mode) // [R22]
      `STQ_MODE_EDGE:
      begin
        if (edge_src == `STQ_SRC_MAINS)
          hit = crossed(cur, was, 1'b0); // [R13]
        else
          hit = crossed(cur, was, edge_fall[edge_src]); // [R12] [R14]
      end
      `STQ_MODE_PULSE:
        hit = p_end && (width_cnt < pulse_w); // [R16] [R17] [R18]
      `STQ_MODE_EXT:
        hit = ext_trig;
      default:
        hit = 1'b0;
    endcase
  end

  // unmapped words read as zero and are refused
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (sel_lvl)
      next_prdata = {16'h0000, upper_threshold[idx]}; // [R3] [R6]
    else if (sel_low)
      next_prdata = {16'h0000, lower_threshold[idx]}; // [R4]
    else
      case (paddr)
        `STQ_CTRL:
          next_prdata = {27'h0, fine_sensitivity, run, mode};
        `STQ_STATUS:
          next_prdata = {29'h0, forced, holding, armed};
        `STQ_HOLD_EDGE:
          next_prdata = hold[mode]; // [R2]
        `STQ_HOLD_PULSE:
          next_prdata = hold[`STQ_MODE_PULSE];
        `STQ_HOLD_EXT:
          next_prdata = hold[`STQ_MODE_EXT];
        `STQ_EDGE_CFG:
          next_prdata = {23'h0, edge_fall[edge_src], 5'h0, edge_src}; // [R15]
        `STQ_PULSE_CFG:
          next_prdata = {27'h0, pulse_neg, 2'b00, pulse_src}; // [R19]
        `STQ_PULSE_W:
          next_prdata = pulse_w;
        `STQ_AUX_LEVEL:
          next_prdata = {16'h0000, aux_level}; // [R8]
        default:
          next_err = 1'b1;
      endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode <= `STQ_MODE_EDGE;
      run <= `STQ_RUN_AUTO;
      fine_sensitivity <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        hold[i] <= `STQ_HOLD_MIN_CYC;
      edge_src <= 3'd0;
      edge_fall <= 6'h00;
      pulse_src <= 2'd0;
      pulse_neg <= 1'b0;
      pulse_w <= 32'h0000_0064;
      aux_level <= 16'h0000;
      for (i = 0; i < 4; i = i + 1)
      begin
        upper_threshold[i] <= 16'h0000;
        lower_threshold[i] <= 16'h0000;
      end
      hold_cnt <= 32'h0000_0000;
      auto_cnt <= 32'h0000_0000;
      width_cnt <= 32'h0000_0000;
      prev <= 6'h00;
      primed <= 2'd0;
      trig_out <= 1'b0;
      acq_start <= 1'b0;
      forced <= 1'b0;
      armed <= 1'b1;
    end
    else
    begin
      // one wait state: answer in the cycle after the access phase starts
      pready <= psel && penable && !pready;
      // refusal is decided in the access phase and shown with pready
      pslverr <= psel && penable && !pready && next_err;
      if (rd)
        prdata <= next_prdata;
      prev <= sync_in;
      trig_out <= 1'b0;
      acq_start <= 1'b0;
      // edges are trusted once both sync stages and prev hold the pin
      if (primed != 2'd3)
        primed <= primed + 2'd1;

      // saturating pulse width counter in clock periods [R24]
      if (!p_act)
        width_cnt <= 32'h0000_0000;
      else if (width_cnt != 32'hFFFF_FFFF)
        width_cnt <= width_cnt + 32'h0000_0001;

      if (holding)
        hold_cnt <= hold_cnt - 32'h0000_0001; // [R1]

      if (armed && !holding)
      begin
        if (accept)
        begin
          trig_out <= 1'b1;
          acq_start <= 1'b1;
          forced <= 1'b0;
          auto_cnt <= 32'h0000_0000;
          hold_cnt <= hold[mode]; // [R1] [R2]
          if (disarm)
            armed <= 1'b0; // [R23]
        end
        else if (run == `STQ_RUN_AUTO)
        begin
          // forcing may beat a slow real trigger; software must know
          if (auto_cnt >= `STQ_AUTO_CYC)
          begin
            acq_start <= 1'b1; // [R9]
            forced <= 1'b1;
            auto_cnt <= 32'h0000_0000;
            // forced sweeps hold off too, so forcing cannot flood capture
            hold_cnt <= hold[mode];
          end
          else
            auto_cnt <= auto_cnt + 32'h0000_0001;
        end
        else
          auto_cnt <= 32'h0000_0000; // [R11]
      end

      if (wr)
      begin
        if (sel_lvl)
          upper_threshold[idx] <= pwdata[15:0]; // [R6] [R7]
        else if (sel_low)
          lower_threshold[idx] <= pwdata[15:0]; // [R4]
        else
          case (paddr)
            `STQ_CTRL:
            begin
              if (pwdata[`STQ_F_MODE_HI:`STQ_F_MODE_LO] != 2'd3)
                mode <= pwdata[`STQ_F_MODE_HI:`STQ_F_MODE_LO];
              if (pwdata[`STQ_F_RUN_HI:`STQ_F_RUN_LO] != 2'd3)
                run <= pwdata[`STQ_F_RUN_HI:`STQ_F_RUN_LO];
              fine_sensitivity <= pwdata[`STQ_F_FINE]; // [R5]
              if (pwdata[`STQ_F_REARM] && !disarm)
                armed <= 1'b1; // [R23]
            end
            `STQ_HOLD_EDGE:
              hold[mode] <= clamp_hold(pwdata); // [R1] [R2]
            `STQ_HOLD_PULSE:
              hold[`STQ_MODE_PULSE] <= clamp_hold(pwdata);
            `STQ_HOLD_EXT:
              hold[`STQ_MODE_EXT] <= clamp_hold(pwdata);
            `STQ_EDGE_CFG:
            begin
              if (pwdata[2:0] <= `STQ_SRC_MAINS)
                edge_src <= pwdata[2:0]; // [R13] [R15]
              // mains keeps no direction
              if (edge_src != `STQ_SRC_MAINS)
                edge_fall[edge_src] <= pwdata[8]; // [R14] [R15]
            end
            `STQ_PULSE_CFG:
            begin
              pulse_src <= pwdata[1:0]; // [R19]
              pulse_neg <= pwdata[4];
              // a count from the old line or polarity would mis-measure
              width_cnt <= 32'h0000_0000;
            end
            `STQ_PULSE_W:
              pulse_w <= (pwdata < `STQ_PW_MIN_CYC) ?
                `STQ_PW_MIN_CYC : pwdata; // [R16]
            `STQ_AUX_LEVEL:
              aux_level <= pwdata[15:0]; // [R8]
            default:
              aux_level <= aux_level;
          endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/stq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module stq_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trig_out,
  input wire logic        acq_start,
  input wire logic        forced,
  input wire logic        armed,
  input wire logic        fine_sensitivity
);
  default clocking mcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence answer_once;
    pready ##1 !pready;
  endsequence
  a_answer_one_wait: assert property (access_wait |=> answer_once)
    else $error("bus answer late or longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error flag outside the answer cycle");
  a_refused_read_zero: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  a_trig_starts_acq: assert property (trig_out |-> acq_start)
    else $error("trigger without acquisition start");
  a_holdoff_gap: assert property (acq_start |=> !acq_start [*8])
    else $error("trigger accepted inside the rearm delay");
  a_real_not_forced: assert property (acq_start && trig_out |-> !forced)
    else $error("qualified trigger flagged as forced");
  a_single_stays_off: assert property (!armed && !$past(armed) |-> !acq_start)
    else $error("acquisition while disarmed");
  a_fine_by_write: assert property ($changed(fine_sensitivity) |->
    (pready && pwrite) || $past(pready && pwrite))
    else $error("noise reject changed without a write");
endmodule
`default_nettype wire

// ===== tb/stq_front.sv
`timescale 1ns/1ps
`default_nettype none
module stq_front
(
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [7:0] len,
  input  wire logic [6:0] base,
  output wire logic [3:0] cmp_chan,
  output wire logic       cmp_aux,
  output wire logic       mains_ref,
  output wire logic       ext_trig
);
  logic [7:0] left = 8'h0;
  logic [6:0] flip = 7'h0;
  // lines change just after an edge, like real comparators seen by the sync
  always @(posedge pclk)
  begin
    if (go)
    begin
      left <= len;
      flip <= 7'h1 << sel;
    end
    else if (left != 8'h0)
      left <= left - 8'h1;
  end
  // lines rest at base; a pulse inverts one line for len cycles
  assign {ext_trig, mains_ref, cmp_aux, cmp_chan} =
    base ^ ((left != 8'h0) ? flip : 7'h0);
endmodule
`default_nettype wire

// ===== tb/scope_trigger_qualifier_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "stq_defs.vh"
module scope_trigger_qualifier_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, trig_out, acq_start, forced, armed;
  logic        fine_sensitivity, cmp_aux, mains_ref, ext_trig, e;
  logic        go = 0;
  logic [2:0]  sel = 0;
  logic [7:0]  len = 0;
  logic [6:0]  base = 0;
  logic [3:0]  cmp_chan;
  int          fails = 0, cmp_count = 0, t, n, trigs, acqs;
  always #5 pclk = ~pclk;
  stq_trigger dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_chan(cmp_chan), .cmp_aux(cmp_aux), .mains_ref(mains_ref),
    .ext_trig(ext_trig), .trig_out(trig_out), .acq_start(acq_start),
    .forced(forced), .armed(armed), .fine_sensitivity(fine_sensitivity));
  stq_front front_u (.pclk(pclk), .go(go), .sel(sel), .len(len),
    .base(base), .cmp_chan(cmp_chan), .cmp_aux(cmp_aux),
    .mains_ref(mains_ref), .ext_trig(ext_trig));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle cycle after each transfer keeps psel from toggling in one step
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 20)
    begin
      fails++;
      report_and_stop;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check(q, x);
  endtask
  // t is the cycle of the first trigger after the pulse starts, or -1
  task automatic shot(input logic [2:0] s, input logic [7:0] l);
    go <= 1'b1;
    sel <= s;
    len <= l;
    @(posedge pclk);
    go <= 1'b0;
    t = -1;
    trigs = 0;
    acqs = 0;
    for (n = 0; n < 60; n++)
    begin
      @(posedge pclk);
      if (trig_out === 1'b1 && t < 0)
        t = n;
      if (trig_out === 1'b1)
        trigs++;
      if (acq_start === 1'b1)
        acqs++;
    end
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`STQ_STATUS, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(`STQ_LEVEL0 + 12'(4 * i), 32'h60 + i);
      wr(`STQ_LOWER0 + 12'(4 * i), 32'h90 + i);
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(`STQ_LEVEL0 + 12'(4 * i), 32'h60 + i);
      rd(`STQ_LOWER0 + 12'(4 * i), 32'h90 + i);
    end
    wr(`STQ_AUX_LEVEL, 32'h77);
    rd(`STQ_AUX_LEVEL, 32'h77);
    $display("levels done");
    wr(`STQ_CTRL, 32'h4);
    wr(`STQ_HOLD_EDGE, 32'ha);
    wr(`STQ_HOLD_PULSE, 32'h1e);
    wr(`STQ_HOLD_EXT, 32'h5);
    rd(`STQ_HOLD_EDGE, 32'ha);
    rd(`STQ_HOLD_EXT, 32'ha);
    wr(`STQ_CTRL, 32'h14);
    check(fine_sensitivity, 1'b1);
    wr(`STQ_CTRL, 32'h4);
    check(fine_sensitivity, 1'b0);
    bus(1'b0, 12'hffc, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0);
    bus(1'b1, 12'hffc, 32'hffff_ffff);
    check(e, 1'b1);
    rd(`STQ_AUX_LEVEL, 32'h77);
    $display("settings done");
    wr(`STQ_EDGE_CFG, 32'h0);
    shot(3'd0, 8'd20);
    check(t >= 0 && t < 20, 1'b1);
    check(forced, 1'b0);
    wr(`STQ_EDGE_CFG, 32'h100);
    rd(`STQ_EDGE_CFG, 32'h100);
    shot(3'd0, 8'd20);
    check(t >= 20, 1'b1);
    for (int s = 4; s < 6; s++)
    begin
      wr(`STQ_EDGE_CFG, 32'(s));
      shot(3'(s), 8'd20);
      check(t >= 0 && t < 20, 1'b1);
    end
    $display("edge done");
    wr(`STQ_CTRL, 32'h5);
    rd(`STQ_HOLD_EDGE, 32'h1e);
    wr(`STQ_PULSE_CFG, 32'h1);
    wr(`STQ_PULSE_W, 32'h8);
    shot(3'd1, 8'd4);
    check(t >= 4 && t < 15, 1'b1);
    shot(3'd1, 8'd12);
    check(t, -1);
    shot(3'd0, 8'd4);
    check(t, -1);
    shot(3'd5, 8'd20);
    check(t, -1);
    base <= 7'h2;
    wr(`STQ_PULSE_CFG, 32'h11);
    shot(3'd1, 8'd4);
    check(t >= 4 && t < 15, 1'b1);
    base <= 7'h0;
    $display("pulse done");
    wr(`STQ_CTRL, 32'h6);
    rd(`STQ_HOLD_EDGE, 32'ha);
    shot(3'd6, 8'd20);
    check(t, 1);
    check(trigs, 2);
    $display("extended done");
    wr(`STQ_CTRL, 32'h8);
    wr(`STQ_EDGE_CFG, 32'h0);
    wr(`STQ_EDGE_CFG, 32'h0);
    shot(3'd0, 8'd4);
    check(t >= 0, 1'b1);
    check(trigs, 1);
    rd(`STQ_STATUS, 32'h0);
    shot(3'd0, 8'd4);
    check(t, -1);
    check(acqs, 0);
    wr(`STQ_CTRL, 32'h108);
    rd(`STQ_STATUS, 32'h1);
    $display("single done");
    report_and_stop;
  end
endmodule
bind stq_trigger stq_monitor mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trig_out(trig_out),
  .acq_start(acq_start), .forced(forced), .armed(armed),
  .fine_sensitivity(fine_sensitivity));
`default_nettype wire
